// ### core/csfr_regs.vh
// Constants for the core special function register set.
// Assumes a single CPU clock and an 8-bit internal SFR bus.
// How it works
// - Only hardware changes the odd-ones bit; software writes to that position are ignored.
// - The odd-ones bit is 1 when the operand/result register has an odd count of set bits, else 0.
// - The half-carry bit is set when an arithmetic operation carries out of bit 3.
// - The carry bit records arithmetic carry and serves as the Boolean bit accumulator.
// - The arithmetic-excess bit is set when an arithmetic operation overflows the signed range.
// - Two user flag bits are freely read and written and never altered by instruction results.
// - The two bank-select bits map R0-R7 to 00H, 08H, 10H or 18H upward in internal data memory.
// - The 8-bit stack pointer addresses the top of stack and resets to 07h.
// - The stack pointer is incremented before data is written for a push or call.
// - The stack pointer is decremented after data is read for a pop, return or service exit.
// - The data pointer pair is one 16-bit value or two independent 8-bit registers.
// - The data pointer is the indirect address for external moves, code reads and computed branches.
// - The operand/result register is the main source and destination, read/write, reset 00h.
// - The auxiliary register is the second operand and extra result of multiply and divide.
// - Every status bit clears on reset; all are read/write except the read-only odd-ones bit.
`ifndef CSFR_REGS_VH
`define CSFR_REGS_VH

// ==========================================
// Offsets
`define CSFR_ADDR_STK    8'h81
`define CSFR_ADDR_PTRLO  8'h82
`define CSFR_ADDR_PTRHI  8'h83
`define CSFR_ADDR_STAT   8'hd0
`define CSFR_ADDR_OPR    8'he0
`define CSFR_ADDR_AUX    8'hf0

// ==========================================
// Reset values
`define CSFR_RST_STK     8'h07
`define CSFR_RST_ZERO    8'h00

// ==========================================
// Status word bit positions
`define CSFR_STAT_CARRY  7
`define CSFR_STAT_HCARRY 6
`define CSFR_STAT_USER0  5
`define CSFR_STAT_BANKHI 4
`define CSFR_STAT_BANKLO 3
`define CSFR_STAT_EXCESS 2
`define CSFR_STAT_USER1  1
`define CSFR_STAT_ODD    0

// ==========================================
// Stack operation codes
`define CSFR_STK_NONE   2'h0
`define CSFR_STK_PUSH   2'h1
`define CSFR_STK_POP    2'h2

`endif

// ### core/csfr_byte_reg.v
// One 8-bit SFR byte with reset value and separate bus/datapath write ports.
// Assumes bus write and datapath load never need to merge; datapath wins.
`timescale 1ns/1ps
module csfr_byte_reg #(
    parameter [7:0] RST_VAL = 8'h00
) (
    // Clock and reset
    input  wire       mclk,
    input  wire       rst_n,
    // Bus write
    input  wire       busWe,
    input  wire [7:0] busData,
    // Datapath load
    input  wire       dpWe,
    input  wire [7:0] dpData,
    // Value
    output reg  [7:0] value_r
);
    // ==========================================
    // Storage
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            value_r <= RST_VAL;
        end else if (dpWe) begin
            value_r <= dpData;
        end else if (busWe) begin
            value_r <= busData;
        end
    end
endmodule // csfr_byte_reg

// ### core/csfr_core_sfr_set.v
// Accumulator, auxiliary, status word, stack pointer and data pointer pair.
// Assumes the CPU datapath drives one-cycle request strobes on mclk.
`timescale 1ns/1ps
`include "csfr_regs.vh"
module csfr_core_sfr_set (
    // Clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // SFR bus
    input  wire [7:0]  sfrAddr,
    input  wire        sfrWe,
    input  wire [7:0]  sfrWdata,
    input  wire        sfrRe,
    output reg  [7:0]  sfrRdata,
    output wire        sfrHit,
    // Accumulator datapath load
    input  wire        accLoad,
    input  wire [7:0]  accIn,
    // Auxiliary register load by multiply/divide
    input  wire        auxLoad,
    input  wire [7:0]  auxIn,
    // Arithmetic flag updates
    input  wire        aluFlagWe,
    input  wire        aluCarry,
    input  wire        aluHalfCarry,
    input  wire        aluExcess,
    input  wire        aluExcessWe,
    // Boolean carry accumulator
    input  wire        bitCarryWe,
    input  wire        bitCarryIn,
    // Stack operation
    input  wire [1:0]  stackOp,
    // Data pointer 16-bit load and increment
    input  wire        ptrLoad,
    input  wire [15:0] ptrIn,
    input  wire        ptrInc,
    // Core state out
    output wire [7:0]  accOut,
    output wire [7:0]  auxOut,
    output wire [7:0]  statusOut,
    output wire        carryFlag,
    output wire [7:0]  stackAddr,
    output wire [4:0]  bankBase,
    output wire [15:0] dataPtrPair
);
    // ==========================================
    // Decode
    wire hitStk   = (sfrAddr == `CSFR_ADDR_STK);
    wire hitPtrLo = (sfrAddr == `CSFR_ADDR_PTRLO);
    wire hitPtrHi = (sfrAddr == `CSFR_ADDR_PTRHI);
    wire hitStat  = (sfrAddr == `CSFR_ADDR_STAT);
    wire hitOpr   = (sfrAddr == `CSFR_ADDR_OPR);
    wire hitAux   = (sfrAddr == `CSFR_ADDR_AUX);
    assign sfrHit = hitStk | hitPtrLo | hitPtrHi | hitStat | hitOpr | hitAux;

    // ==========================================
    // Operand/result and auxiliary
    wire [7:0] opr_r;
    wire [7:0] aux_r;

    csfr_byte_reg #(.RST_VAL(`CSFR_RST_ZERO)) uOpr (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .busWe   (sfrWe & hitOpr),
        .busData (sfrWdata),
        .dpWe    (accLoad),
        .dpData  (accIn),
        .value_r (opr_r)
    );

    csfr_byte_reg #(.RST_VAL(`CSFR_RST_ZERO)) uAux (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .busWe   (sfrWe & hitAux),
        .busData (sfrWdata),
        .dpWe    (auxLoad),
        .dpData  (auxIn),
        .value_r (aux_r)
    );

    // ==========================================
    // Status word, bits 7..1 stored; odd-ones bit is derived
    reg  [7:1] stat_r;
    reg  [7:1] stat_nxt;
    wire [7:0] oddChain;
    // Parity from the live register, so no stale cycle after a load
    assign oddChain[0] = opr_r[0];
    genvar gi;
    generate
        for (gi = 1; gi < 8; gi = gi + 1) begin : gOdd
            assign oddChain[gi] = oddChain[gi-1] ^ opr_r[gi];
        end
    endgenerate
    wire       oddOnes = oddChain[7];

    always @* begin
        stat_nxt = stat_r;
        if (sfrWe && hitStat) begin
            stat_nxt = sfrWdata[7:1];
        end
        if (aluFlagWe) begin
            stat_nxt[`CSFR_STAT_CARRY]  = aluCarry;
            stat_nxt[`CSFR_STAT_HCARRY] = aluHalfCarry;
        end
        if (aluExcessWe) begin
            stat_nxt[`CSFR_STAT_EXCESS] = aluExcess;
        end
        if (bitCarryWe) begin
            stat_nxt[`CSFR_STAT_CARRY] = bitCarryIn;
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stat_r <= 7'h00;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    // ==========================================
    // Stack pointer
    reg [7:0] stkPtr_r;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stkPtr_r <= `CSFR_RST_STK;
        end else if (stackOp == `CSFR_STK_PUSH) begin
            stkPtr_r <= stkPtr_r + 8'h01;
        end else if (stackOp == `CSFR_STK_POP) begin
            stkPtr_r <= stkPtr_r - 8'h01;
        end else if (sfrWe && hitStk) begin
            stkPtr_r <= sfrWdata;
        end
    end
    // Push writes at the incremented address in the same cycle
    assign stackAddr = (stackOp == `CSFR_STK_PUSH) ? (stkPtr_r + 8'h01) : stkPtr_r;

    // ==========================================
    // Data pointer pair
    reg  [7:0]  ptrLo_r;
    reg  [7:0]  ptrHi_r;
    wire [15:0] ptrPlus1 = {ptrHi_r, ptrLo_r} + 16'h0001;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ptrLo_r <= `CSFR_RST_ZERO;
            ptrHi_r <= `CSFR_RST_ZERO;
        end else if (ptrLoad) begin
            {ptrHi_r, ptrLo_r} <= ptrIn;
        end else if (ptrInc) begin
            {ptrHi_r, ptrLo_r} <= ptrPlus1;
        end else begin
            if (sfrWe && hitPtrLo) begin
                ptrLo_r <= sfrWdata;
            end
            if (sfrWe && hitPtrHi) begin
                ptrHi_r <= sfrWdata;
            end
        end
    end

    // ==========================================
    // Read mux; unmapped reads as zero
    always @* begin
        sfrRdata = 8'h00;
        if (!sfrRe) begin
            sfrRdata = 8'h00;
        end else if (hitStk) begin
            sfrRdata = stkPtr_r;
        end else if (hitPtrLo) begin
            sfrRdata = ptrLo_r;
        end else if (hitPtrHi) begin
            sfrRdata = ptrHi_r;
        end else if (hitStat) begin
            sfrRdata = {stat_r, oddOnes};
        end else if (hitOpr) begin
            sfrRdata = opr_r;
        end else if (hitAux) begin
            sfrRdata = aux_r;
        end
    end

    // ==========================================
    // State out
    assign accOut      = opr_r;
    assign auxOut      = aux_r;
    assign statusOut   = {stat_r, oddOnes};
    assign carryFlag   = stat_r[`CSFR_STAT_CARRY];
    assign bankBase    = {stat_r[`CSFR_STAT_BANKHI:`CSFR_STAT_BANKLO], 3'h0};
    assign dataPtrPair = {ptrHi_r, ptrLo_r};
endmodule // csfr_core_sfr_set

// ### tb/csfr_core_props.sv
// Checker for the core SFR set; sees top-level ports only.
// Assumes one clock mclk and asynchronous active-low rst_n.
`timescale 1ns/1ps
module csfr_core_props (
    // Clock and reset
    input wire       mclk,
    input wire       rst_n,
    // Bus and datapath
    input wire [7:0] sfrAddr,
    input wire       sfrWe,
    input wire [7:0] sfrWdata,
    input wire       accLoad,
    input wire [7:0] accIn,
    input wire [1:0] stackOp,
    // State
    input wire [7:0] accOut,
    input wire [7:0] statusOut,
    input wire [7:0] stackAddr,
    input wire [4:0] bankBase
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // Properties
    property p_par; statusOut[0] == ^accOut; endproperty
    a_par: assert property (p_par) else $error("parity off");
    property p_stab; $stable(accOut) |-> $stable(statusOut[0]); endproperty
    a_stab: assert property (p_stab) else $error("parity moved alone");
    property p_push; stackOp == 2'h1 |=> stackAddr == $past(stackAddr) + {7'h0, stackOp == 2'h1}; endproperty
    a_push: assert property (p_push) else $error("push address");
    property p_pop; stackOp == 2'h2 |=> stackAddr == $past(stackAddr) - 8'h01 + {7'h0, stackOp == 2'h1}; endproperty
    a_pop: assert property (p_pop) else $error("pop address");
    property p_accw; sfrWe && sfrAddr == 8'he0 && !accLoad |=> accOut == $past(sfrWdata); endproperty
    a_accw: assert property (p_accw) else $error("acc bus write");
    property p_accl; accLoad |=> accOut == $past(accIn); endproperty
    a_accl: assert property (p_accl) else $error("acc load");
    property p_bank; bankBase == {statusOut[4:3], 3'h0}; endproperty
    a_bank: assert property (p_bank) else $error("bank base");
    property p_rst; $rose(rst_n) |-> stackAddr == 8'h07; endproperty
    a_rst: assert property (p_rst) else $error("sp reset");
endmodule // csfr_core_props

// ### tb/csfr_stack_mem.sv
// Stack area of internal data memory, addressed by the core's stack pointer.
// Assumes at most one stack operation per cycle.
`timescale 1ns/1ps
module csfr_stack_mem (
    // Clock
    input  wire       mclk,
    // Stack port
    input  wire [1:0] stackOp,
    input  wire [7:0] stackAddr,
    input  wire [7:0] pushData,
    output wire [7:0] popData
);
    reg [7:0] mem [0:255];
    always @(posedge mclk) if (stackOp == 2'h1) mem[stackAddr] <= pushData;
    // Not held outside a pop: show junk, never a stale byte
    assign popData = (stackOp == 2'h2) ? mem[stackAddr] : ~mem[stackAddr];
endmodule // csfr_stack_mem

// ### tb/csfr_core_sfr_set_tb.sv
// Self-checking bench for the core SFR set.
// Assumes the stack memory model and the property checker beside it.
`timescale 1ns/1ps
module csfr_core_sfr_set_tb;
    logic mclk = 0, rst_n = 0, sfrWe, sfrRe, accLoad, auxLoad, aluFlagWe, aluCarry, aluHalfCarry;
    logic aluExcess, aluExcessWe, bitCarryWe, bitCarryIn, ptrLoad, ptrInc, sfrHit, carryFlag;
    logic [7:0] sfrAddr, sfrWdata, accIn, auxIn, pushData, sfrRdata, accOut, auxOut, statusOut, stackAddr, popData, v;
    logic [1:0] stackOp;
    logic [15:0] ptrIn, dataPtrPair;
    logic [4:0] bankBase;
    logic [7:0] q[$];
    logic [7:0] ad[7] = '{8'h81, 8'h82, 8'h83, 8'hd0, 8'he0, 8'hf0, 8'h80};
    logic [7:0] rv[7] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    int num_errors = 0, n_checks = 0, cyc = 0;
    always #12.5 mclk = ~mclk;
    csfr_core_sfr_set u_dut (.*);
    csfr_stack_mem u_mem (.mclk, .stackOp, .stackAddr, .pushData, .popData);
    // ==========================================
    // Tasks
    task step; @(posedge mclk) #1; endtask
    task chk(input string n, input [15:0] s, e);
        n_checks++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch %s exp %h got %h", n, e, s);
        end
    endtask
    task wr(input [7:0] a, d); step; sfrAddr = a; sfrWdata = d; sfrWe = 1; step; sfrWe = 0; endtask
    task rd(input [7:0] a, e); step; sfrAddr = a; sfrRe = 1; q.push_back(e); step; sfrRe = 0; endtask
    task end_of_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ==========================================
    // Result watcher
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            end_of_test;
        end
        if (sfrRe) chk("rdata", sfrRdata, q.pop_front());
        if (stackOp == 2'h2) chk("pop", popData, q.pop_front());
    end
    // ==========================================
    // Stimulus
    initial begin
        {sfrWe, sfrRe, accLoad, auxLoad, aluFlagWe, aluCarry, aluHalfCarry, aluExcess} = '0;
        {aluExcessWe, bitCarryWe, bitCarryIn, ptrLoad, ptrInc, stackOp} = '0;
        {sfrAddr, sfrWdata, accIn, auxIn, pushData, ptrIn} = '0;
        void'($urandom(32'hfa83));
        repeat (16) @(posedge mclk);
        #1 rst_n = 1;
        for (int i = 0; i < 7; i++) rd(ad[i], rv[i]);
        // Acc is still zero when the status word is read back
        for (int i = 0; i < 7; i++) begin
            v = $urandom;
            wr(ad[i], v);
            rd(ad[i], i == 6 ? 8'h00 : i == 3 ? {v[7:1], 1'b0} : v);
            chk("hit", sfrHit, 16'(i != 6));
        end
        for (int b = 0; b < 4; b++) begin
            wr(8'hd0, 8'(b * 8));
            chk("bank", bankBase, 16'(b * 8));
        end
        v = $urandom;
        step; accLoad = 1; accIn = v; step; accLoad = 0;
        chk("acc", accOut, {8'h00, v});
        rd(8'hd0, {7'h0c, ^v});
        v = $urandom;
        step; auxLoad = 1; auxIn = v; step; auxLoad = 0;
        chk("aux", auxOut, {8'h00, v});
        rd(8'hf0, v);
        wr(8'he0, 8'h01);
        wr(8'hd0, 8'h22);
        step; {aluFlagWe, aluCarry, aluHalfCarry, aluExcessWe, aluExcess} = 5'h1f;
        step; {aluFlagWe, aluExcessWe} = 2'h0;
        rd(8'hd0, 8'he7);
        step; {bitCarryWe, bitCarryIn, aluFlagWe} = 3'h5;
        step; {bitCarryWe, aluFlagWe} = 2'h0;
        chk("carry", carryFlag, 16'h0000);
        wr(8'h81, 8'h20);
        step; stackOp = 2'h1; pushData = 8'ha5;
        step; pushData = 8'h3c;
        step; stackOp = 2'h2; q.push_back(8'h3c);
        step; q.push_back(8'ha5);
        step; stackOp = 2'h0;
        rd(8'h81, 8'h20);
        step; ptrLoad = 1; ptrIn = 16'h12ff;
        step; ptrLoad = 0; ptrInc = 1;
        step; ptrInc = 0;
        chk("data_ptr_pair", dataPtrPair, 16'h1300);
        wr(8'h82, 8'h7e);
        rd(8'h83, 8'h13);
        rd(8'h82, 8'h7e);
        end_of_test;
    end
endmodule // csfr_core_sfr_set_tb
bind csfr_core_sfr_set csfr_core_props u_props (.*);
